/* hdl/rsi_pkg.sv */
`default_nettype none
package rsi_pkg;
    // ----------------------------------------
    // register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] RSI_OFF_CMD = 8'h00;
    localparam logic [7:0] RSI_OFF_CTRL = 8'h04;
    localparam logic [7:0] RSI_OFF_STATUS = 8'h08;
    localparam logic [7:0] RSI_OFF_IRQ_STAT = 8'h0C;
    localparam logic [7:0] RSI_OFF_IRQ_MASK = 8'h10;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int RSI_CMD_SERVO_ON = 0;
    localparam int RSI_CMD_SERVO_OFF = 1;
    localparam int RSI_CMD_ALARM_RST = 2;
    localparam int RSI_CMD_START = 3;
    localparam int RSI_CMD_STOP = 4;
    localparam int RSI_CTRL_BRAKE = 0;
    localparam int RSI_CTRL_W = 1;
    localparam int RSI_EVT_SKIP = 0;
    localparam int RSI_EVT_DOOR = 1;
    localparam int RSI_EVT_ENAB = 2;
    localparam int RSI_EVT_KEY = 3;
    localparam int RSI_EVT_REFUSE = 4;
    localparam int RSI_EVT_W = 5;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [RSI_CTRL_W-1:0] RSI_CTRL_RST = 1'h0;
    localparam logic [RSI_EVT_W-1:0] RSI_IRQ_MASK_RST = 5'h00;
    localparam logic [RSI_EVT_W-1:0] RSI_IRQ_STAT_RST = 5'h00;
    localparam int RSI_SYNC_STAGES = 2;

    // switch inputs, high = contact closed / switch pressed
    typedef struct packed {
        logic skip;
        logic door_a;
        logic door_b;
        logic enab_a;
        logic enab_b;
        logic key_a;
        logic key_b;
        logic pend_en;
        logic pend_sw;
    } rsi_sw_t;
endpackage : rsi_pkg
`default_nettype wire

/* hdl/rsi_top.sv */
// Operation
// - an active special stop input stops robot motion
// - door open stops the robot unless teaching permissions apply
// - door open in automatic drops servo and stops; it raises error only if servo was on
// - recovery order: close door, reset alarm, servo on, restart
// - teaching with door open may still servo on and jog
// - door open: servo on needs pendant switch and enabling device held
// - releasing the enabling device drops servo power at once
// - enabling device released refuses brake release, and servo on with door open
// - manual, door closed: servo on from the pendant alone
// - manual, pendant enabled, switch on, enabling closed: jog, any door
// - enabling open: jog in manual only with door closed
// - brake release needs manual, pendant enabled, both switches held
// - automatic only in auto mode, pendant disabled, door closed
// - mode follows key lines only when they agree, else key fault
`default_nettype none
module rsi_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire rsi_pkg::rsi_sw_t sw_in,
    output logic servo_power,
    output logic brake_release,
    output logic motion_stop,
    output logic robot_error,
    output logic mode_auto,
    output logic jog_permit,
    output logic auto_running,
    output logic key_fault,
    output logic irq
);
    import rsi_pkg::*;

    // ----------------------------------------
    // input synchroniser
    // ----------------------------------------
    localparam int SW_W = $bits(rsi_sw_t);
    logic [SW_W-1:0] sync_q [RSI_SYNC_STAGES];
    logic [SW_W-1:0] sync_d [RSI_SYNC_STAGES];
    rsi_sw_t sw;

    always_comb begin
        sync_d[0] = sw_in;
        for (int i = 1; i < RSI_SYNC_STAGES; i++) begin
            sync_d[i] = sync_q[i-1];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < RSI_SYNC_STAGES; i++) begin
                sync_q[i] <= '0;
            end
        end else begin
            sync_q <= sync_d;
        end
    end

    assign sw = rsi_sw_t'(sync_q[RSI_SYNC_STAGES-1]);

    // ----------------------------------------
    // state registers
    // ----------------------------------------
    // declared early: permissions and status words read them
    logic servo_q, servo_d, brake_q, brake_d, motion_q, motion_d;
    logic error_q, error_d, mode_q, mode_d, jog_q, jog_d;
    logic auto_q, auto_d, keyf_q, keyf_d, enab_prev_q, skip_prev_q;
    logic [RSI_EVT_W-1:0] stat_q, stat_d, evt;
    logic irq_q, irq_d;

    // ----------------------------------------
    // decoded permissions
    // ----------------------------------------
    // dual-line door and enabling inputs: a single open line counts as open, the safe reading
    logic door_ok, enab_ok, keys_agree, teach_ok, jog_ok, auto_ok, servo_ok;

    always_comb begin
        door_ok = sw.door_a & sw.door_b;
        enab_ok = sw.enab_a & sw.enab_b;
        keys_agree = sw.key_a == sw.key_b;
        teach_ok = !mode_q & sw.pend_en & sw.pend_sw;
        jog_ok = teach_ok & (enab_ok | door_ok);
        auto_ok = mode_q & !sw.pend_en & door_ok;
        if (mode_q) begin
            servo_ok = !error_q & door_ok & !sw.pend_en;
        end else if (door_ok) begin
            servo_ok = !error_q & sw.pend_en;
        end else begin
            servo_ok = !error_q & sw.pend_en & sw.pend_sw & enab_ok;
        end
    end

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d, pslverr_q, pslverr_d;
    logic [RSI_CTRL_W-1:0] ctrl_q, ctrl_d;
    logic [RSI_EVT_W-1:0] mask_q, mask_d;
    logic wr, mapped;
    logic [4:0] cmd;
    logic [RSI_EVT_W-1:0] w1c;
    logic [31:0] status;

    always_comb begin
        wr = psel & penable & pready_q & pwrite;
        mapped = paddr inside {RSI_OFF_CMD, RSI_OFF_CTRL, RSI_OFF_STATUS, RSI_OFF_IRQ_STAT, RSI_OFF_IRQ_MASK};
        cmd = (wr && paddr == RSI_OFF_CMD) ? pwdata[4:0] : 5'h00;
        w1c = (wr && paddr == RSI_OFF_IRQ_STAT) ? pwdata[RSI_EVT_W-1:0] : '0;
        ctrl_d = (wr && paddr == RSI_OFF_CTRL) ? pwdata[RSI_CTRL_W-1:0] : ctrl_q;
        mask_d = (wr && paddr == RSI_OFF_IRQ_MASK) ? pwdata[RSI_EVT_W-1:0] : mask_q;
        status = {22'h0, motion_q, enab_ok, door_ok, keyf_q, error_q,
                  mode_q, auto_q, jog_q, brake_q, servo_q};
        // answer is prepared in setup, so every access completes in one cycle
        pready_d = psel & !penable;
        pslverr_d = psel & !penable & !mapped;
        prdata_d = prdata_q;
        if (psel && !penable) begin
            unique case (paddr)
                RSI_OFF_CTRL: prdata_d = 32'(ctrl_q);
                RSI_OFF_STATUS: prdata_d = status;
                RSI_OFF_IRQ_STAT: prdata_d = 32'(stat_q);
                RSI_OFF_IRQ_MASK: prdata_d = 32'(mask_q);
                default: prdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata_q <= 32'h00000000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            ctrl_q <= RSI_CTRL_RST;
            mask_q <= RSI_IRQ_MASK_RST;
        end else begin
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            ctrl_q <= ctrl_d;
            mask_q <= mask_d;
        end
    end

    // ----------------------------------------
    // interlock state
    // ----------------------------------------
    logic enab_fall, door_trip, refuse;

    always_comb begin
        enab_fall = enab_prev_q & !enab_ok;
        door_trip = mode_q & !door_ok & (servo_q | auto_q);
        refuse = cmd[RSI_CMD_SERVO_ON] & !servo_ok;
        // key lines disagreeing hold the mode and flag a fault
        mode_d = keys_agree ? sw.key_a : mode_q;
        keyf_d = !keys_agree;
        error_d = error_q;
        if (cmd[RSI_CMD_ALARM_RST] && door_ok && keys_agree) begin
            error_d = 1'b0;
        end
        if (door_trip || !keys_agree) begin
            error_d = 1'b1;
        end
        servo_d = servo_q;
        if (cmd[RSI_CMD_SERVO_ON] && servo_ok) begin
            servo_d = 1'b1;
        end
        // a drop always beats a request arriving in the same cycle
        if (cmd[RSI_CMD_SERVO_OFF] || enab_fall || error_d || mode_d != mode_q) begin
            servo_d = 1'b0;
        end
        if (mode_q ? !door_ok : (!door_ok && !enab_ok)) begin
            servo_d = 1'b0;
        end
        auto_d = auto_q;
        if (cmd[RSI_CMD_START] && servo_q && auto_ok && !error_q && !sw.skip) begin
            auto_d = 1'b1;
        end
        if (cmd[RSI_CMD_STOP] || !auto_ok || !servo_d || sw.skip) begin
            auto_d = 1'b0;
        end
        brake_d = ctrl_q[RSI_CTRL_BRAKE] & teach_ok & enab_ok;
        jog_d = jog_ok;
        motion_d = sw.skip | error_d | (mode_q & !door_ok) | (!mode_q & !jog_ok);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            servo_q <= 1'b0;
            brake_q <= 1'b0;
            motion_q <= 1'b1;
            error_q <= 1'b0;
            mode_q <= 1'b0;
            jog_q <= 1'b0;
            auto_q <= 1'b0;
            keyf_q <= 1'b0;
            enab_prev_q <= 1'b0;
            skip_prev_q <= 1'b0;
        end else begin
            servo_q <= servo_d;
            brake_q <= brake_d;
            motion_q <= motion_d;
            error_q <= error_d;
            mode_q <= mode_d;
            jog_q <= jog_d;
            auto_q <= auto_d;
            keyf_q <= keyf_d;
            enab_prev_q <= enab_ok;
            skip_prev_q <= sw.skip;
        end
    end

    // ----------------------------------------
    // interrupts
    // ----------------------------------------
    always_comb begin
        evt = '0;
        evt[RSI_EVT_SKIP] = sw.skip & !skip_prev_q;
        evt[RSI_EVT_DOOR] = door_trip;
        evt[RSI_EVT_ENAB] = enab_fall & servo_q;
        evt[RSI_EVT_KEY] = !keys_agree & !keyf_q;
        evt[RSI_EVT_REFUSE] = refuse;
        // set wins over a same-cycle clear
        stat_d = (stat_q & ~w1c) | evt;
        irq_d = |(stat_d & mask_d);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stat_q <= RSI_IRQ_STAT_RST;
            irq_q <= 1'b0;
        end else begin
            stat_q <= stat_d;
            irq_q <= irq_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign servo_power = servo_q;
    assign brake_release = brake_q;
    assign motion_stop = motion_q;
    assign robot_error = error_q;
    assign mode_auto = mode_q;
    assign jog_permit = jog_q;
    assign auto_running = auto_q;
    assign key_fault = keyf_q;
    assign irq = irq_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_skip_stops: assert property (@(posedge clk) disable iff (rst)
        sw.skip |=> motion_q && !auto_q)
        else $error("special stop did not stop motion");

    a_door_auto_trip: assert property (@(posedge clk) disable iff (rst)
        (mode_q && !door_ok && servo_q) |=> (!servo_q && error_q && motion_q))
        else $error("door open in automatic not handled");

    a_alarm_needs_door: assert property (@(posedge clk) disable iff (rst)
        $fell(error_q) |-> $past(door_ok))
        else $error("alarm cleared with door open");

    a_open_servo_on: assert property (@(posedge clk) disable iff (rst)
        ($rose(servo_q) && !$past(door_ok) && !$past(mode_q)) |-> $past(enab_ok && sw.pend_sw))
        else $error("servo on with door open lacked both switches");

    a_enab_release_off: assert property (@(posedge clk) disable iff (rst)
        (enab_prev_q && !enab_ok) |=> !servo_q)
        else $error("servo stayed on after enabling release");

    a_jog_door_needed: assert property (@(posedge clk) disable iff (rst)
        (jog_q && !$past(enab_ok)) |-> $past(door_ok && teach_ok))
        else $error("jog permitted with enabling and door open");

    a_brake_needs_enab: assert property (@(posedge clk) disable iff (rst)
        brake_q |-> $past(enab_ok && teach_ok))
        else $error("brake released without switches held");

    a_auto_door_closed: assert property (@(posedge clk) disable iff (rst)
        (auto_q && !door_ok) |=> !auto_q)
        else $error("automatic kept running with door open");

    a_key_fault_hold: assert property (@(posedge clk) disable iff (rst)
        (sw.key_a != sw.key_b) |=> (keyf_q && robot_error && $stable(mode_q)))
        else $error("key line fault not flagged or mode moved");

    a_irq_level: assert property (@(posedge clk) disable iff (rst)
        irq_q == |(stat_q & mask_q))
        else $error("interrupt high without unmasked status");
endmodule // rsi_top
`default_nettype wire

/* bench/rsi_sw_model.sv */
`default_nettype none
module rsi_sw_model
    import rsi_pkg::*;
(
    input wire logic door_shut,
    input wire logic enab_held,
    input wire logic key_auto,
    input wire logic key_split,
    input wire logic skip,
    input wire logic pend_en,
    input wire logic pend_sw,
    output var rsi_pkg::rsi_sw_t sw
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // contacts
    // ----------------------------------------
    // both lines of a pair move together; key_split breaks one key line
    assign sw = {skip, door_shut, door_shut, enab_held, enab_held, key_auto, key_auto ^ key_split,
        pend_en, pend_sw};
endmodule // rsi_sw_model
`default_nettype wire

/* bench/tb_top.sv */
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rsi_pkg::*;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, irq, er;
    logic sp, br, ms, re, ma, jp, ar, kf;
    logic door_shut = 1, enab_held = 0, key_auto = 0, key_split = 0, skip = 0, pend_en = 1, pend_sw = 0;
    rsi_sw_t sw;
    int fail_count = 0, checks = 0, cyc = 0;
    wire logic [7:0] outs = {sp, br, jp, ms, re, ma, ar, kf};
    always #2.5 clk = ~clk;
    rsi_sw_model rsi_sw_model_i (.door_shut(door_shut), .enab_held(enab_held), .key_auto(key_auto),
        .key_split(key_split), .skip(skip), .pend_en(pend_en), .pend_sw(pend_sw), .sw(sw));
    rsi_top rsi_top_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sw_in(sw), .servo_power(sp), .brake_release(br), .motion_stop(ms), .robot_error(re),
        .mode_auto(ma), .jog_permit(jp), .auto_running(ar), .key_fault(kf), .irq(irq));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic end_sim();
        if (fail_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cmd(input int b);
        apb(1'b1, RSI_OFF_CMD, 32'h1 << b);
        settle(2);
    endtask
    task automatic cout(input logic [7:0] exp, input logic [7:0] m);
        chk("outputs", {24'h0, exp & m}, {24'h0, outs & m});
    endtask
    // hang guard, generous against roughly 160 cycles of tests
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            end_sim();
        end
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        settle(6);
        cout(8'h10, 8'hFF);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, er});
        chk("unmapped_data", 32'h0, rd);
        cmd(RSI_CMD_SERVO_ON);
        cout(8'h90, 8'hFF);
        pend_sw <= 1'b1;
        settle(5);
        cout(8'hA0, 8'hFF);
        cmd(RSI_CMD_SERVO_OFF);
        door_shut <= 1'b0;
        settle(5);
        cmd(RSI_CMD_SERVO_ON);
        cout(8'h10, 8'hFF);
        apb(1'b0, RSI_OFF_IRQ_STAT, 32'h0);
        chk("irq_stat", 32'h10, rd);
        apb(1'b1, RSI_OFF_IRQ_MASK, 32'h10);
        settle(2);
        chk("irq_on", 32'h1, {31'h0, irq});
        apb(1'b1, RSI_OFF_IRQ_STAT, 32'h10);
        settle(2);
        chk("irq_off", 32'h0, {31'h0, irq});
        enab_held <= 1'b1;
        settle(5);
        cmd(RSI_CMD_SERVO_ON);
        cout(8'hA0, 8'hFF);
        apb(1'b1, RSI_OFF_CTRL, 32'h1);
        settle(2);
        cout(8'hE0, 8'hFF);
        enab_held <= 1'b0;
        settle(5);
        cout(8'h10, 8'hFF);
        key_auto <= 1'b1;
        key_split <= 1'b1;
        settle(5);
        cout(8'h19, 8'hFF);
        door_shut <= 1'b1;
        pend_en <= 1'b0;
        pend_sw <= 1'b0;
        key_split <= 1'b0;
        settle(5);
        cmd(RSI_CMD_ALARM_RST);
        cmd(RSI_CMD_SERVO_ON);
        cmd(RSI_CMD_START);
        cout(8'h86, 8'hEF);
        door_shut <= 1'b0;
        settle(5);
        cout(8'h1C, 8'hFF);
        apb(1'b0, RSI_OFF_IRQ_STAT, 32'h0);
        chk("irq_stat", 32'h0E, rd);
        // alarm reset is ignored until the door is shut again
        cmd(RSI_CMD_ALARM_RST);
        cout(8'h08, 8'h08);
        door_shut <= 1'b1;
        settle(5);
        cmd(RSI_CMD_ALARM_RST);
        cmd(RSI_CMD_SERVO_ON);
        cmd(RSI_CMD_START);
        cout(8'h86, 8'hEF);
        cmd(RSI_CMD_STOP);
        cout(8'h84, 8'hEF);
        cmd(RSI_CMD_START);
        cout(8'h86, 8'hEF);
        skip <= 1'b1;
        settle(5);
        cout(8'h10, 8'h12);
        apb(1'b0, RSI_OFF_IRQ_STAT, 32'h0);
        chk("irq_stat", 32'h0F, rd);
        apb(1'b0, RSI_OFF_STATUS, 32'h0);
        chk("status", 32'h291, rd);
        end_sim();
    end
endmodule // tb_top
`default_nettype wire
